// File: hdl/fboe_engine.sv
/*
 * Order engine: takes frame bit-block-transfer orders byte by byte from the
 * link and runs them pixel by pixel against a bit-addressed memory port.
 * Assumes a memory on the same clock that answers each held request with a
 * one-cycle ack, and set-up values on the link that stay still during an
 * order.
 */
// Function
// - Opcode 10: reserved byte, then destination-only rop
// - Destination pitch is always the frame width
// - Opcode 12: source address, source/destination rop
// - Source pitch: stored non-zero pitch, else width
// - Opcode 13: remainders, halftone address, three-operand rop
// - Halftone fetch wraps at map edges
// - Remainders lie in one to map size
// - Issuer sets remainders for chosen start pixel
// - Issuer gives upper-left corner addresses
// - Halftone map dimensions defined before use
// - Opcode 16: pitch, scale bytes, source/destination rop
// - Source expanded before the raster combination
// - Frame within scaled source size, else partial
// - Scaled order steps source by own pitch
// - Unsupported horizontal code means no horizontal scaling
// - Horizontal clip skips leftmost expanded bits
// - Vertical factor is code plus one
// - Vertical clip skips top expanded scanlines
`timescale 1ns/1ns
`default_nettype none
`include "fboe_params.svh"

module fboe_engine #(
	parameter logic [15:0] X_SCALE_SUPPORTED = 16'hFFFF
) (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	fboe_link_if.engine link,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [31:0] mem_addr_o,
	output logic mem_wbit_o,
	input wire logic mem_ack_i,
	input wire logic mem_rbit_i,
	output logic order_done_o,
	output logic bad_opcode_o
);
	fboe_pkg::fboe_eng_t r;
	fboe_pkg::fboe_eng_t next_r;

	// ------------------------------------------------------------------
	// Parameter fields of the collected order
	// ------------------------------------------------------------------
	logic [7:0] opc;
	logic [31:0] f_da;
	logic [31:0] f_sa;
	logic [31:0] f_ha;
	logic [15:0] f_fw;
	logic [15:0] f_fh;
	logic [15:0] f_hxr;
	logic [15:0] f_hyr;
	logic [15:0] f_sw;
	logic [7:0] f_xb;
	logic [7:0] f_yb;
	logic rop_bit;
	logic [31:0] ht_back;

	// Big-endian fields, as the core builds them in memory
	assign opc = r.ob[0];
	assign f_da = {r.ob[`FBOE_POS_DA], r.ob[`FBOE_POS_DA+1], r.ob[`FBOE_POS_DA+2],
		r.ob[`FBOE_POS_DA+3]};
	assign f_fw = {r.ob[`FBOE_POS_FW], r.ob[`FBOE_POS_FW+1]};
	assign f_fh = {r.ob[`FBOE_POS_FH], r.ob[`FBOE_POS_FH+1]};
	assign f_sa = {r.ob[`FBOE_POS_SA], r.ob[`FBOE_POS_SA+1], r.ob[`FBOE_POS_SA+2],
		r.ob[`FBOE_POS_SA+3]};
	assign f_hxr = {r.ob[`FBOE_POS_HXR], r.ob[`FBOE_POS_HXR+1]};
	assign f_hyr = {r.ob[`FBOE_POS_HYR], r.ob[`FBOE_POS_HYR+1]};
	assign f_ha = {r.ob[`FBOE_POS_HA], r.ob[`FBOE_POS_HA+1], r.ob[`FBOE_POS_HA+2],
		r.ob[`FBOE_POS_HA+3]};
	assign f_sw = {r.ob[`FBOE_POS_SW], r.ob[`FBOE_POS_SW+1]};
	assign f_xb = r.ob[`FBOE_POS_XB];
	assign f_yb = r.ob[`FBOE_POS_YB];

	// Distance from a halftone column back to the map's top row
	assign ht_back = 32'(32'(link.halftone_height - 16'h0001) * 32'(link.halftone_width));

	// ------------------------------------------------------------------
	// Raster combination: the code is a truth table over the operands
	// ------------------------------------------------------------------
	always_comb begin
		unique case (opc)
			`FBOE_OP_DEST_ONLY: rop_bit = link.dest_only_rop_code[mem_rbit_i];
			`FBOE_OP_SRC_HT_DEST: rop_bit = link.src_ht_dest_rop_code[{r.sbit, r.hbit, mem_rbit_i}];
			default: rop_bit = link.src_dest_rop_code[{r.sbit, mem_rbit_i}];
		endcase
	end

	// Ready only while taking bytes; an order never overlaps another
	assign link.ord_ready = (r.st == fboe_pkg::ENG_IDLE) || (r.st == fboe_pkg::ENG_COLLECT);
	assign link.engine_busy = (r.st != fboe_pkg::ENG_IDLE);
	assign mem_req_o = r.mem_req;
	assign mem_we_o = r.mem_we;
	assign mem_addr_o = r.mem_addr;
	assign mem_wbit_o = r.mem_wbit;
	assign order_done_o = r.done;
	assign bad_opcode_o = r.bad;

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		next_r.bad = 1'b0;
		unique case (r.st)
			fboe_pkg::ENG_IDLE: begin
				if (link.ord_valid) begin
					next_r.ob[0] = link.ord_byte;
					next_r.idx = 5'd1;
					next_r.st = fboe_pkg::ENG_COLLECT;
					unique case (link.ord_byte)
						`FBOE_OP_DEST_ONLY: next_r.len = `FBOE_LEN_DEST_ONLY;
						`FBOE_OP_SRC_DEST: next_r.len = `FBOE_LEN_SRC_DEST;
						`FBOE_OP_SRC_HT_DEST: next_r.len = `FBOE_LEN_SRC_HT_DEST;
						`FBOE_OP_EXP_SRC_DEST: next_r.len = `FBOE_LEN_EXP_SRC_DEST;
						default: begin
							// Unknown opcode: drop this byte only and resync on the next
							next_r.st = fboe_pkg::ENG_IDLE;
							next_r.bad = 1'b1;
						end
					endcase
				end
			end
			fboe_pkg::ENG_COLLECT: begin
				if (link.ord_valid) begin
					// The reserved byte is stored but never read
					next_r.ob[r.idx] = link.ord_byte;
					next_r.idx = r.idx + 5'd1;
					if (r.idx == r.len - 5'd1) begin
						next_r.st = fboe_pkg::ENG_SETUP;
					end
				end
			end
			fboe_pkg::ENG_SETUP: begin
				next_r.fw = f_fw;
				next_r.fh = f_fh;
				next_r.x = 16'h0000;
				next_r.y = 16'h0000;
				next_r.dp = f_da;
				next_r.drow = f_da;
				next_r.sp = f_sa;
				next_r.srow = f_sa;
				next_r.fx = 5'd1;
				next_r.fy = 5'd1;
				next_r.xs0 = 4'h0;
				next_r.xs = 4'h0;
				next_r.ys = 4'h0;
				next_r.spitch = (link.src_map_pitch != 16'h0000) ? link.src_map_pitch : f_fw;
				next_r.hp = f_ha;
				next_r.hline = f_ha;
				next_r.hxr0 = f_hxr;
				next_r.halftone_x_remaining = f_hxr;
				next_r.halftone_y_remaining = f_hyr;
				if (opc == `FBOE_OP_EXP_SRC_DEST) begin
					next_r.spitch = f_sw;
					next_r.fy = 5'({1'b0, f_yb[3:0]}) + 5'd1;
					next_r.ys = f_yb[7:4];
					if (X_SCALE_SUPPORTED[f_xb[3:0]]) begin
						next_r.fx = 5'({1'b0, f_xb[3:0]}) + 5'd1;
						next_r.xs0 = f_xb[7:4];
						next_r.xs = f_xb[7:4];
					end
				end
				// An empty frame finishes with no memory traffic
				if (f_fw == 16'h0000 || f_fh == 16'h0000) begin
					next_r.st = fboe_pkg::ENG_IDLE;
					next_r.done = 1'b1;
				end else if (opc == `FBOE_OP_DEST_ONLY) begin
					next_r.st = fboe_pkg::ENG_RD_D;
				end else begin
					next_r.st = fboe_pkg::ENG_RD_S;
				end
			end
			fboe_pkg::ENG_RD_S, fboe_pkg::ENG_RD_H, fboe_pkg::ENG_RD_D: begin
				if (!r.mem_req) begin
					next_r.mem_req = 1'b1;
					next_r.mem_we = 1'b0;
					next_r.mem_addr = (r.st == fboe_pkg::ENG_RD_S) ? r.sp :
						(r.st == fboe_pkg::ENG_RD_H) ? r.hp : r.dp;
				end else if (mem_ack_i) begin
					next_r.mem_req = 1'b0;
					if (r.st == fboe_pkg::ENG_RD_S) begin
						next_r.sbit = mem_rbit_i;
						next_r.st = (opc == `FBOE_OP_SRC_HT_DEST) ? fboe_pkg::ENG_RD_H :
							fboe_pkg::ENG_RD_D;
					end else if (r.st == fboe_pkg::ENG_RD_H) begin
						next_r.hbit = mem_rbit_i;
						next_r.st = fboe_pkg::ENG_RD_D;
					end else begin
						next_r.mem_wbit = rop_bit;
						next_r.st = fboe_pkg::ENG_WR_D;
					end
				end
			end
			fboe_pkg::ENG_WR_D: begin
				if (!r.mem_req) begin
					next_r.mem_req = 1'b1;
					next_r.mem_we = 1'b1;
					next_r.mem_addr = r.dp;
				end else if (mem_ack_i) begin
					next_r.mem_req = 1'b0;
					next_r.mem_we = 1'b0;
					next_r.st = fboe_pkg::ENG_STEP;
				end
			end
			fboe_pkg::ENG_STEP: begin
				next_r.st = (opc == `FBOE_OP_DEST_ONLY) ? fboe_pkg::ENG_RD_D : fboe_pkg::ENG_RD_S;
				if (r.x != r.fw - 16'h0001) begin
					// Along the scanline
					next_r.x = r.x + 16'h0001;
					next_r.dp = r.dp + 32'h0000_0001;
					if (5'({1'b0, r.xs}) >= r.fx - 5'd1) begin
						next_r.xs = 4'h0;
						next_r.sp = r.sp + 32'h0000_0001;
					end else begin
						next_r.xs = r.xs + 4'h1;
					end
					if (r.halftone_x_remaining <= 16'h0001) begin
						next_r.halftone_x_remaining = link.halftone_width;
						next_r.hp = r.hp - 32'(link.halftone_width) + 32'h0000_0001;
					end else begin
						next_r.halftone_x_remaining = r.halftone_x_remaining - 16'h0001;
						next_r.hp = r.hp + 32'h0000_0001;
					end
				end else if (r.y == r.fh - 16'h0001) begin
					next_r.st = fboe_pkg::ENG_IDLE;
					next_r.done = 1'b1;
				end else begin
					// Next scanline: destination packed at the frame width
					next_r.x = 16'h0000;
					next_r.y = r.y + 16'h0001;
					next_r.drow = r.drow + 32'(r.fw);
					next_r.dp = r.drow + 32'(r.fw);
					next_r.xs = r.xs0;
					next_r.sp = r.srow;
					if (5'({1'b0, r.ys}) >= r.fy - 5'd1) begin
						next_r.ys = 4'h0;
						next_r.srow = r.srow + 32'(r.spitch);
						next_r.sp = r.srow + 32'(r.spitch);
					end else begin
						next_r.ys = r.ys + 4'h1;
					end
					next_r.halftone_x_remaining = r.hxr0;
					if (r.halftone_y_remaining <= 16'h0001) begin
						next_r.halftone_y_remaining = link.halftone_height;
						next_r.hline = r.hline - ht_back;
						next_r.hp = r.hline - ht_back;
					end else begin
						next_r.halftone_y_remaining = r.halftone_y_remaining - 16'h0001;
						next_r.hline = r.hline + 32'(link.halftone_width);
						next_r.hp = r.hline + 32'(link.halftone_width);
					end
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule

`default_nettype wire

// File: hdl/fboe_params.svh
/*
 * Constants of the frame bit-block-transfer order engine: order opcodes,
 * order lengths, parameter byte positions, host register offsets and
 * reset values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef FBOE_PARAMS_SVH
`define FBOE_PARAMS_SVH

// ----------------------------------------------------------------------
// Order opcodes and reserved byte
// ----------------------------------------------------------------------
`define FBOE_OP_DEST_ONLY 8'h10
`define FBOE_OP_SRC_DEST 8'h12
`define FBOE_OP_SRC_HT_DEST 8'h13
`define FBOE_OP_EXP_SRC_DEST 8'h16
`define FBOE_RESERVED_BYTE 8'h00

// ----------------------------------------------------------------------
// Order lengths in bytes, opcode included
// ----------------------------------------------------------------------
`define FBOE_LEN_DEST_ONLY 5'd10
`define FBOE_LEN_SRC_DEST 5'd14
`define FBOE_LEN_SRC_HT_DEST 5'd22
`define FBOE_LEN_EXP_SRC_DEST 5'd18
`define FBOE_MAX_LEN 22

// ----------------------------------------------------------------------
// Parameter byte positions, most significant byte first
// ----------------------------------------------------------------------
`define FBOE_POS_DA 2
`define FBOE_POS_FW 6
`define FBOE_POS_FH 8
`define FBOE_POS_SA 10
`define FBOE_POS_HXR 14
`define FBOE_POS_HYR 16
`define FBOE_POS_HA 18
`define FBOE_POS_SW 14
`define FBOE_POS_XB 16
`define FBOE_POS_YB 17

// ----------------------------------------------------------------------
// Issuer register byte offsets and fields
// ----------------------------------------------------------------------
`define FBOE_REG_ORDER 8'h00
`define FBOE_REG_ROP 8'h04
`define FBOE_REG_SRC_PITCH 8'h08
`define FBOE_REG_HT_DIMS 8'h0C
`define FBOE_REG_STATUS 8'h10
`define FBOE_ROP_D_LSB 0
`define FBOE_ROP_SD_LSB 4
`define FBOE_ROP_SHD_LSB 8
`define FBOE_HT_W_LSB 0
`define FBOE_HT_H_LSB 16
`define FBOE_RST_ROP 32'h0000_0000
`define FBOE_RST_SRC_PITCH 32'h0000_0000
`define FBOE_RST_HT_DIMS 32'h0001_0001

`endif

// File: hdl/fboe_pkg.sv
/*
 * Types shared by both ends of the order engine: the engine's state enumeration and
 * the packed state records of each end.
 * Assumes the params header for the order buffer size.
 */
`include "fboe_params.svh"

package fboe_pkg;
	// ------------------------------------------------------------------
	// Engine sequencing
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ENG_IDLE, ENG_COLLECT, ENG_SETUP, ENG_RD_S, ENG_RD_H, ENG_RD_D, ENG_WR_D,
		ENG_STEP
	} fboe_eng_st_t;

	typedef struct packed {
		fboe_eng_st_t st;
		logic [4:0] idx;
		logic [4:0] len;
		logic [`FBOE_MAX_LEN-1:0][7:0] ob;
		logic [15:0] fw;
		logic [15:0] fh;
		logic [15:0] x;
		logic [15:0] y;
		logic [31:0] dp;
		logic [31:0] drow;
		logic [31:0] sp;
		logic [31:0] srow;
		logic [15:0] spitch;
		logic [31:0] hp;
		logic [31:0] hline;
		logic [15:0] hxr0;
		logic [15:0] halftone_x_remaining;
		logic [15:0] halftone_y_remaining;
		logic [4:0] fx;
		logic [4:0] fy;
		logic [3:0] xs0;
		logic [3:0] xs;
		logic [3:0] ys;
		logic sbit;
		logic hbit;
		logic mem_req;
		logic mem_we;
		logic [31:0] mem_addr;
		logic mem_wbit;
		logic done;
		logic bad;
	} fboe_eng_t;

	// ------------------------------------------------------------------
	// Issuer register file
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [31:0] rop;
		logic [31:0] src_pitch;
		logic [31:0] ht_dims;
		logic [7:0] ord_byte;
		logic ord_valid;
		logic ack;
		logic [31:0] dat;
	} fboe_iss_t;
endpackage

// File: hdl/fboe_link_if.sv
/*
 * Link between the order issuer and the engine: a byte stream of orders
 * with valid/ready, plus the set-up state that the issuer's registers hold.
 * Assumes one clock for both ends.
 */
`timescale 1ns/1ns
`default_nettype none

interface fboe_link_if;
	logic ord_valid;
	logic [7:0] ord_byte;
	logic ord_ready;
	logic [1:0] dest_only_rop_code;
	logic [3:0] src_dest_rop_code;
	logic [7:0] src_ht_dest_rop_code;
	logic [15:0] src_map_pitch;
	logic [15:0] halftone_width;
	logic [15:0] halftone_height;
	logic engine_busy;

	modport issuer (
		output ord_valid, ord_byte, dest_only_rop_code, src_dest_rop_code,
		output src_ht_dest_rop_code, src_map_pitch, halftone_width, halftone_height,
		input ord_ready, engine_busy
	);
	modport engine (
		input ord_valid, ord_byte, dest_only_rop_code, src_dest_rop_code,
		input src_ht_dest_rop_code, src_map_pitch, halftone_width, halftone_height,
		output ord_ready, engine_busy
	);
endinterface

`default_nettype wire

// File: hdl/fboe_issuer.sv
/*
 * Order issuer: a classic Wishbone slave through which software feeds
 * order bytes to the engine and sets the raster codes and map values
 * that the set-up orders would otherwise carry.
 * Assumes the engine on the same clock behind the link interface.
 */
`timescale 1ns/1ns
`default_nettype none
`include "fboe_params.svh"

module fboe_issuer (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	fboe_link_if.issuer link
);
	fboe_pkg::fboe_iss_t r;
	fboe_pkg::fboe_iss_t next_r;
	logic req;

	// Byte-lane merge of a register write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[8*i +: 8] = val[8*i +: 8];
			end
		end
		return res;
	endfunction

	// ------------------------------------------------------------------
	// Link drive
	// ------------------------------------------------------------------
	assign link.ord_valid = r.ord_valid;
	assign link.ord_byte = r.ord_byte;
	assign link.dest_only_rop_code = r.rop[`FBOE_ROP_D_LSB +: 2];
	assign link.src_dest_rop_code = r.rop[`FBOE_ROP_SD_LSB +: 4];
	assign link.src_ht_dest_rop_code = r.rop[`FBOE_ROP_SHD_LSB +: 8];
	assign link.src_map_pitch = r.src_pitch[15:0];
	// Map dimensions must be set before a halftone order is fed
	assign link.halftone_width = r.ht_dims[`FBOE_HT_W_LSB +: 16];
	assign link.halftone_height = r.ht_dims[`FBOE_HT_H_LSB +: 16];
	assign wb_dat_o = r.dat;
	assign wb_ack_o = r.ack;
	assign req = wb_cyc_i && wb_stb_i && !r.ack;

	// ------------------------------------------------------------------
	// Register access; an order byte stalls its ack while one is pending
	// ------------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.ack = 1'b0;
		if (r.ord_valid && link.ord_ready) begin
			next_r.ord_valid = 1'b0;
		end
		if (req) begin
			next_r.ack = 1'b1;
			next_r.dat = 32'h0000_0000;
			unique case (wb_adr_i)
				`FBOE_REG_ORDER: begin
					if (wb_we_i) begin
						if (r.ord_valid) begin
							next_r.ack = 1'b0;
						end else if (wb_sel_i[0]) begin
							next_r.ord_byte = wb_dat_i[7:0];
							next_r.ord_valid = 1'b1;
						end
					end
				end
				`FBOE_REG_ROP: begin
					if (wb_we_i) begin
						next_r.rop = merge(r.rop, wb_dat_i, wb_sel_i) & 32'h0000_FFF3;
					end
					next_r.dat = r.rop;
				end
				`FBOE_REG_SRC_PITCH: begin
					if (wb_we_i) begin
						next_r.src_pitch = merge(r.src_pitch, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
					end
					next_r.dat = r.src_pitch;
				end
				`FBOE_REG_HT_DIMS: begin
					if (wb_we_i) begin
						next_r.ht_dims = merge(r.ht_dims, wb_dat_i, wb_sel_i);
					end
					next_r.dat = r.ht_dims;
				end
				`FBOE_REG_STATUS: begin
					next_r.dat = {30'h0000_0000, r.ord_valid, link.engine_busy};
				end
				default: begin
					next_r.dat = 32'h0000_0000;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			r <= '0;
			r.rop <= `FBOE_RST_ROP;
			r.src_pitch <= `FBOE_RST_SRC_PITCH;
			r.ht_dims <= `FBOE_RST_HT_DIMS;
		end else begin
			r <= next_r;
		end
	end
endmodule

`default_nettype wire

// File: verification/fboe_link_sva.sv
/*
 * Checker beside the link between issuer and engine, watching the order
 * handshake, the engine's memory port and its status pulses.
 * Assumes one clock and an active-low asynchronous reset for both ends.
 */
`timescale 1ns/1ns
`default_nettype none
`include "fboe_params.svh"

module fboe_link_sva (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic ord_valid,
	input wire logic [7:0] ord_byte,
	input wire logic ord_ready,
	input wire logic engine_busy,
	input wire logic mem_req_o,
	input wire logic mem_we_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic mem_wbit_o,
	input wire logic mem_ack_i,
	input wire logic order_done_o,
	input wire logic bad_opcode_o
);
	// ------------------------------------------------------------------
	// Helper terms
	// ------------------------------------------------------------------
	logic idle_take;
	logic is_op;

	// Opcode bytes only count when the engine is idle
	assign idle_take = ord_valid && ord_ready && !engine_busy;
	assign is_op = (ord_byte == `FBOE_OP_DEST_ONLY) || (ord_byte == `FBOE_OP_SRC_DEST) ||
		(ord_byte == `FBOE_OP_SRC_HT_DEST) || (ord_byte == `FBOE_OP_EXP_SRC_DEST);

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	a_op_starts_order: assert property (idle_take && is_op |=> engine_busy)
		else $error("known opcode did not start an order");
	a_bad_op_dropped: assert property (idle_take && !is_op |=> bad_opcode_o && !engine_busy)
		else $error("unknown opcode not dropped with a pulse");
	a_bad_op_pulse: assert property (bad_opcode_o |=> !bad_opcode_o)
		else $error("bad opcode flag longer than one cycle");
	a_done_one_cycle: assert property (order_done_o |=> !order_done_o)
		else $error("done flag longer than one cycle");
	a_req_held_stable: assert property (mem_req_o && !mem_ack_i |=>
		mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wbit_o))
		else $error("memory request changed before its answer");
	a_req_released: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
		else $error("memory request kept after its answer");
	a_exec_not_ready: assert property (mem_req_o |-> !ord_ready && engine_busy)
		else $error("engine took bytes while running an order");
	a_done_to_idle: assert property (order_done_o |-> ##[0:1] !engine_busy)
		else $error("engine still busy after finishing an order");
endmodule

`default_nettype wire

// File: verification/frame_bitblt_order_engine_tb.sv
/*
 * Self-checking bench: drives the issuer over classic Wishbone, plays a
 * one-cycle bit memory for the engine and judges the frames written.
 * Assumes both ends meet over the link interface on one 10 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none

module frame_bitblt_order_engine_tb;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0000_0000;
	logic [31:0] wb_q;
	logic wb_ack;
	logic mem_req, mem_we, mem_wbit, order_done, bad_opcode;
	logic [31:0] mem_addr;
	logic mem_ack = 1'b0;
	logic mem_rbit = 1'b0;
	logic mem [0:8191];
	logic snap [0:8191];
	int miscompares = 0;
	int checks_done = 0;

	fboe_link_if link_bus();

	fboe_issuer i_fboe_issuer (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack), .link(link_bus));

	// Code 2 left out so the unsupported-scale path is reachable
	fboe_engine #(.X_SCALE_SUPPORTED(16'hFFFB)) i_fboe_engine (.sys_clk_i(sys_clk),
		.reset_n_i(reset_n), .link(link_bus), .mem_req_o(mem_req), .mem_we_o(mem_we),
		.mem_addr_o(mem_addr), .mem_wbit_o(mem_wbit), .mem_ack_i(mem_ack),
		.mem_rbit_i(mem_rbit), .order_done_o(order_done), .bad_opcode_o(bad_opcode));

	fboe_link_sva i_fboe_link_sva (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
		.ord_valid(link_bus.ord_valid), .ord_byte(link_bus.ord_byte),
		.ord_ready(link_bus.ord_ready), .engine_busy(link_bus.engine_busy),
		.mem_req_o(mem_req), .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_wbit_o(mem_wbit),
		.mem_ack_i(mem_ack), .order_done_o(order_done), .bad_opcode_o(bad_opcode));

	// ------------------------------------------------------------------
	// Clock and bit memory
	// ------------------------------------------------------------------
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end

	// Read bit toggles outside answers so a stale sample never matches by luck
	always @(posedge sys_clk) begin
		if (mem_req && !mem_ack) begin
			mem_ack <= 1'b1;
			mem_rbit <= mem[mem_addr[12:0]];
			if (mem_we) begin
				mem[mem_addr[12:0]] <= mem_wbit;
			end
		end else begin
			mem_ack <= 1'b0;
			mem_rbit <= ~mem_rbit;
		end
	end

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic stop_test;
		if (miscompares == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One classic cycle, held until ack is seen at a rising edge
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge sys_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dat <= d;
		wb_sel <= 4'hF;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 200);
		q = wb_q;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (n >= 200) begin
			miscompares++;
			stop_test;
		end
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, adr, d, q);
	endtask

	task automatic wait_done;
		int n;
		n = 0;
		while (order_done !== 1'b1 && n < 5000) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 5000) begin
			miscompares++;
			stop_test;
		end
	endtask

	// Bytes go out most significant first, the order right-justified in v
	task automatic order(input int n, input logic [175:0] v);
		snap = mem;
		for (int i = 0; i < n; i++) begin
			wr(8'h00, {24'h00_0000, v[8*(n-1-i) +: 8]});
		end
		wait_done;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_regs;
		logic [7:0] a [5] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
		logic [31:0] e [5] = '{32'h0000_0000, 32'h0000_0000, 32'h0001_0001, 32'h0000_0000,
			32'h0000_0000};
		logic [31:0] q;
		wr(8'h20, 32'hFFFF_FFFF);
		for (int i = 0; i < 5; i++) begin
			wb(1'b0, a[i], 32'h0000_0000, q);
			chk(q, e[i]);
		end
	endtask

	// Inverting code; a stray opcode first must be dropped alone
	task automatic t_dest;
		wr(8'h04, 32'h0000_CCC1);
		wr(8'h00, 32'h0000_0011);
		order(10, {8'h10, 8'h00, 32'h0000_0100, 16'h0005, 16'h0002});
		for (int i = 0; i < 12; i++) begin
			chk({31'h0, mem['h100 + i]}, {31'h0, (i < 10) ? ~snap['h100 + i] : snap['h100 + i]});
		end
		// Empty frame must finish with the destination left alone
		order(10, {8'h10, 8'h00, 32'h0000_0100, 16'h0000, 16'h0002});
		chk({31'h0, mem['h100]}, {31'h0, snap['h100]});
	endtask

	// Copy code with frame width pitch, then a stored pitch of eight
	task automatic t_sd;
		for (int k = 0; k < 2; k++) begin
			wr(8'h08, 32'(k * 8));
			order(14, {8'h12, 8'h00, 32'h0000_0300, 16'h0003, 16'h0002, 32'h0000_0200});
			for (int p = 0; p < 6; p++) begin
				chk({31'h0, mem['h300 + p]}, {31'h0, snap['h200 + (p / 3) * (k ? 8 : 3) + p % 3]});
			end
		end
	endtask

	// Three by two map, mid-pattern then upper-left; halftone-only code shows tiling
	task automatic t_ht;
		wr(8'h08, 32'h0000_0000);
		wr(8'h0C, 32'h0002_0003);
		for (int k = 0; k < 2; k++) begin
			order(22, {8'h13, 8'h00, 32'h0000_0600, 16'h0005, 16'h0003, 32'h0000_0500,
				(k ? 16'h0003 : 16'h0002), (k ? 16'h0002 : 16'h0001),
				(k ? 32'h0000_0400 : 32'h0000_0404)});
			for (int p = 0; p < 15; p++) begin
				chk({31'h0, mem['h600 + p]},
					{31'h0, snap['h400 + ((1 - k + p / 5) % 2) * 3 + (1 - k + p % 5) % 3]});
			end
		end
	endtask

	// Factor two with one clipped bit, then code 2 which is unsupported here
	task automatic t_exp;
		int sc;
		int sr;
		wr(8'h08, 32'h0000_0007);
		for (int k = 0; k < 2; k++) begin
			order(18, {8'h16, 8'h00, 32'(32'h0000_0800 + k * 64), 16'h0003, 16'h0004,
				32'h0000_0700, 16'h0004, (k ? 8'h12 : 8'h11), 8'h12});
			for (int p = 0; p < 12; p++) begin
				sc = k ? p % 3 : (p % 3 + 1) / 2;
				sr = (p / 3 + 1) / 3;
				chk({31'h0, mem['h800 + k * 64 + p]},
					{31'h0, snap['h700 + sr * 4 + sc]});
			end
		end
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		for (int i = 0; i < 8192; i++) begin
			mem[i] = ^(i & 'h5B);
		end
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_regs;
		t_dest;
		t_sd;
		t_ht;
		t_exp;
		stop_test;
	end
endmodule

`default_nettype wire
